/* File: irq_vector_priority_latency.sv */
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
module irq_vector_priority_latency import irq_vector_pkg::*; #(
	parameter int FLAGS = FLAGS_PER_SOURCE
) (
	input  wire logic                              core_clk,
	input  wire logic                              rst_b,
	input  wire logic [NUM_SOURCES-1:0][FLAGS-1:0] srcFlags,
	input  wire logic                              busVoltageLevel,
	input  wire logic                              instrBoundary,
	input  wire logic                              retiDone,
	input  wire logic                              cpuStall,
	input  reg_req_s                               regReq,
	output logic      [7:0]                        rdData,
	output logic                                   callActive,
	output logic      [15:0]                       callVector,
	output logic                                   vectorTaken,
	output logic      [NUM_SOURCES-1:0]            hwClear,
	output logic                                   irq
);
	// ============================================================
	// elaboration checks
	if (FLAGS < 1) begin : g_bad_flags
		$error("FLAGS must be at least one");
	end
	if (CALL_CYCLES < 1 || CALL_CYCLES > 8) begin : g_bad_call
		$error("call length must fit the three-bit call counter");
	end
	if (NUM_SOURCES != MAIN_BITS + EXT1_BITS + 2) begin : g_bad_map
		$error("source count does not match the enable register map");
	end

	// ============================================================
	// request gathering
	logic [NUM_SOURCES-1:0] pending;
	logic [NUM_SOURCES-1:0] enableReg;
	logic [NUM_SOURCES-1:0] prioReg;
	logic                   globalEnReg;

	for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_src
		if (s == ORDER_BUS_LEVEL) begin : g_level
			assign pending[s] = busVoltageLevel;
		end else begin : g_flags
			assign pending[s] = |srcFlags[s];
		end
	end

	wire logic [NUM_SOURCES-1:0] request = pending & enableReg & {NUM_SOURCES{globalEnReg}};

	// ============================================================
	// arbitration
	logic   activeHighReg;
	logic   activeLowReg;
	grant_s grant;
	grant_s grantReg;

	irq_priority_arbiter u_arb (
		.request   (request),
		.highPrio  (prioReg),
		.activeHigh(activeHighReg),
		.activeLow (activeLowReg),
		.grant     (grant)
	);

	// ============================================================
	// call sequencer
	seq_state_e       stateReg;
	seq_state_e       stateNext;
	logic [2:0]       callCntReg;
	logic [ORDER_W-1:0] callOrderReg;
	logic             callHighReg;

	wire logic step       = !cpuStall;
	wire logic boundary   = instrBoundary && step;
	// the one instruction after a return may itself be a return (nested routines)
	wire logic inIdle     = (stateReg == ST_IDLE);
	wire logic inHold     = (stateReg == ST_HOLD);
	wire logic popReturn  = (inIdle || inHold) && boundary && retiDone;
	wire logic fromIdle   = inIdle && boundary && !retiDone;
	wire logic fromHold   = inHold && boundary && !retiDone;
	wire logic startCall  = (fromIdle || fromHold) && grantReg.valid;
	wire logic callDone   = (stateReg == ST_CALL) && step && (callCntReg == 3'h0);
	wire logic [15:0] vecOf = VECTOR_BASE +
		{{(16 - ORDER_W - VECTOR_STEP_LOG2){1'b0}}, grantReg.order, 3'b000};

	always_comb begin
		stateNext = stateReg;
		case (stateReg)
			ST_IDLE: begin
				if (popReturn) begin
					stateNext = ST_HOLD;
				end else if (startCall) begin
					stateNext = ST_CALL;
				end
			end
			ST_HOLD: begin
				if (popReturn) begin
					stateNext = ST_HOLD;
				end else if (startCall) begin
					stateNext = ST_CALL;
				end else if (fromHold) begin
					stateNext = ST_IDLE;
				end
			end
			ST_CALL: begin
				if (callDone) begin
					stateNext = ST_IDLE;
				end
			end
			default: stateNext = ST_IDLE;
		endcase
	end

	// detection stage: one registered cycle between flag and decision;
	// a grant taken before the in-service bit rose is stale when the call ends
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			grantReg <= '0;
		end else if (callDone) begin
			grantReg <= '0;
		end else begin
			grantReg <= grant;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			stateReg   <= ST_IDLE;
			callCntReg <= 3'h0;
		end else begin
			stateReg <= stateNext;
			if (startCall) begin
				callCntReg <= 3'(CALL_CYCLES - 1);
			end else if ((stateReg == ST_CALL) && step && (callCntReg != 3'h0)) begin
				callCntReg <= callCntReg - 3'h1;
			end
		end
	end

	// reset leaves the vector at the top entry until the first call
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			callVector   <= RESET_VECTOR;
			callOrderReg <= '0;
			callHighReg  <= 1'b0;
		end else if (startCall) begin
			callVector   <= vecOf;
			callOrderReg <= grantReg.order;
			callHighReg  <= grantReg.high;
		end
	end

	// flags of orders 0 to 3 are cleared as the call starts, so a re-arm during the call is seen
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hwClear <= '0;
		end else begin
			hwClear <= startCall ? (HW_CLEAR_SOURCES & (17'h00001 << grantReg.order)) : '0;
		end
	end

	// in-service levels: pushed when the call completes, popped by return
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			activeHighReg <= 1'b0;
			activeLowReg  <= 1'b0;
		end else if (callDone) begin
			if (callHighReg) begin
				activeHighReg <= 1'b1;
			end else begin
				activeLowReg <= 1'b1;
			end
		end else if (popReturn) begin
			if (activeHighReg) begin
				activeHighReg <= 1'b0;
			end else begin
				activeLowReg <= 1'b0;
			end
		end
	end

	assign callActive = (stateReg == ST_CALL);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			vectorTaken <= 1'b0;
		end else begin
			vectorTaken <= callDone;
		end
	end

	// ============================================================
	// register port
	wire logic selEnMain = regReq.addr == OFF_ENABLE_MAIN;
	wire logic selEnExt1 = regReq.addr == OFF_ENABLE_EXT1;
	wire logic selEnExt2 = regReq.addr == OFF_ENABLE_EXT2;
	wire logic selPrMain = regReq.addr == OFF_PRIO_MAIN;
	wire logic selPrExt1 = regReq.addr == OFF_PRIO_EXT1;
	wire logic selPrExt2 = regReq.addr == OFF_PRIO_EXT2;
	wire logic selStatus = regReq.addr == OFF_EVT_STATUS;
	wire logic selMask   = regReq.addr == OFF_EVT_MASK;
	wire logic selState  = regReq.addr == OFF_STATE;
	wire logic wr        = regReq.wrStb;
	wire logic [NUM_SOURCES-1:0] fieldWr = {regReq.wrData[1:0], regReq.wrData, regReq.wrData[6:0]};
	wire logic [NUM_SOURCES-1:0] enSel   = {{2{selEnExt2}}, {EXT1_BITS{selEnExt1}},
		{MAIN_BITS{selEnMain}}};
	wire logic [NUM_SOURCES-1:0] prSel   = {{2{selPrExt2}}, {EXT1_BITS{selPrExt1}},
		{MAIN_BITS{selPrMain}}};

	logic [2:0] evtStatusReg;
	logic [2:0] evtMaskReg;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			enableReg   <= ENABLE_RESET;
			prioReg     <= PRIO_RESET;
			globalEnReg <= 1'b0;
			evtMaskReg  <= EVT_RESET;
		end else if (wr) begin
			enableReg <= (enableReg & ~enSel) | (fieldWr & enSel);
			prioReg   <= (prioReg & ~prSel) | (fieldWr & prSel);
			if (selEnMain) begin
				globalEnReg <= regReq.wrData[GLOBAL_EN_BIT];
			end
			if (selMask) begin
				evtMaskReg <= regReq.wrData[2:0];
			end
		end
	end

	// ============================================================
	// events and interrupt line
	wire logic [2:0] evtSet = {popReturn, startCall && activeLowReg, callDone};
	wire logic [2:0] evtClr = (wr && selStatus) ? regReq.wrData[2:0] : 3'h0;

	// a new event in the clearing cycle survives
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			evtStatusReg <= EVT_RESET;
		end else begin
			evtStatusReg <= (evtStatusReg & ~evtClr) | evtSet;
		end
	end

	assign irq = |(evtStatusReg & evtMaskReg);

	wire logic [7:0] rdMux =
		selEnMain ? {globalEnReg, enableReg[6:0]} :
		selEnExt1 ? enableReg[14:7] :
		selEnExt2 ? {6'h00, enableReg[16:15]} :
		selPrMain ? {1'b0, prioReg[6:0]} :
		selPrExt1 ? prioReg[14:7] :
		selPrExt2 ? {6'h00, prioReg[16:15]} :
		selStatus ? {5'h00, evtStatusReg} :
		selMask   ? {5'h00, evtMaskReg} :
		selState  ? {activeHighReg, activeLowReg, callActive, callOrderReg} :
		8'h00;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData <= 8'h00;
		end else begin
			rdData <= regReq.rdStb ? rdMux : 8'h00;
		end
	end

	// ============================================================
	// checks
	logic [3:0] callLenReg;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			callLenReg <= 4'h0;
		end else if (startCall) begin
			callLenReg <= 4'h0;
		end else if (callActive && step) begin
			callLenReg <= callLenReg + 4'h1;
		end
	end

	chk_call_length: assert property (@(posedge core_clk) disable iff (!rst_b)
		callDone |-> callLenReg == 4'(CALL_CYCLES - 1))
		else $error("long call did not last five active cycles");
	chk_call_after_detect: assert property (@(posedge core_clk) disable iff (!rst_b)
		(stateReg == ST_IDLE && boundary && !retiDone && grantReg.valid) |=> callActive)
		else $error("recognized request not called at boundary");
	chk_hold_one_instr: assert property (@(posedge core_clk) disable iff (!rst_b)
		popReturn |=> stateReg == ST_HOLD && !callActive)
		else $error("call issued directly after return");
	chk_stall_freeze: assert property (@(posedge core_clk) disable iff (!rst_b)
		cpuStall |=> stateReg == $past(stateReg) && callCntReg == $past(callCntReg))
		else $error("sequencer advanced during stall");
	chk_vector_map: assert property (@(posedge core_clk) disable iff (!rst_b)
		vectorTaken |-> callVector == VECTOR_BASE + {8'h00, callOrderReg, 3'b000})
		else $error("vector does not match order");
	chk_hw_clear_set: assert property (@(posedge core_clk) disable iff (!rst_b)
		(|hwClear) |-> (hwClear & ~HW_CLEAR_SOURCES) == '0 && $past(startCall))
		else $error("hardware cleared a software-owned flag");
	chk_global_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
		!globalEnReg |=> !grantReg.valid)
		else $error("request recognized with global enable off");
	chk_high_no_preempt: assert property (@(posedge core_clk) disable iff (!rst_b)
		activeHighReg |-> !grant.valid)
		else $error("running high routine preempted");
	chk_low_waits: assert property (@(posedge core_clk) disable iff (!rst_b)
		(activeLowReg && grant.valid) |-> grant.high)
		else $error("equal priority request preempted low routine");
	chk_reset_vector: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(rst_b) |-> callVector == RESET_VECTOR)
		else $error("reset vector not at top entry");
	chk_no_reentry: assert property (@(posedge core_clk) disable iff (!rst_b)
		vectorTaken |-> !startCall)
		else $error("routine re-entered right after its own call");
	chk_pop_order: assert property (@(posedge core_clk) disable iff (!rst_b)
		(popReturn && activeHighReg) |=> !activeHighReg && $stable(activeLowReg))
		else $error("return did not leave the high routine first");
	chk_usb_kept: assert property (@(posedge core_clk) disable iff (!rst_b)
		!hwClear[ORDER_USB] && !hwClear[ORDER_BUS_LEVEL])
		else $error("hardware cleared a flag it does not own");

	cov_plain_call: cover property (@(posedge core_clk) disable iff (!rst_b)
		startCall ##1 callActive [*5] ##1 vectorTaken);
	cov_return_then_call: cover property (@(posedge core_clk) disable iff (!rst_b)
		popReturn ##[1:20] startCall);
	cov_preempt: cover property (@(posedge core_clk) disable iff (!rst_b)
		startCall && activeLowReg);
	cov_stall_in_call: cover property (@(posedge core_clk) disable iff (!rst_b)
		callActive && cpuStall);
	cov_hold_call: cover property (@(posedge core_clk) disable iff (!rst_b)
		popReturn ##[1:16] (stateReg == ST_HOLD && startCall));
endmodule : irq_vector_priority_latency

/* File: irq_priority_arbiter.sv */
`timescale 1ns/10ps
// ============================================================
// shared constants and types
package irq_vector_pkg;
	localparam int             NUM_SOURCES      = 17;
	localparam int             ORDER_W          = 5;
	localparam int             FLAGS_PER_SOURCE = 4;
	localparam int             DETECT_CYCLES    = 1;
	localparam int             CALL_CYCLES      = 5;
	localparam int             RESPONSE_MIN     = DETECT_CYCLES + CALL_CYCLES;
	localparam logic [15:0]    RESET_VECTOR     = 16'h0000;
	localparam logic [15:0]    VECTOR_BASE      = 16'h0003;
	localparam int             VECTOR_STEP_LOG2 = 3;
	localparam logic [16:0]    HW_CLEAR_SOURCES = 17'h0000f;
	localparam int             ORDER_USB        = 8;
	localparam int             ORDER_BUS_LEVEL  = 15;
	localparam int             MAIN_BITS        = 7;
	localparam int             EXT1_BITS        = 8;
	localparam int             GLOBAL_EN_BIT    = 7;
	localparam logic [3:0]     OFF_ENABLE_MAIN  = 4'h0;
	localparam logic [3:0]     OFF_ENABLE_EXT1  = 4'h1;
	localparam logic [3:0]     OFF_ENABLE_EXT2  = 4'h2;
	localparam logic [3:0]     OFF_PRIO_MAIN    = 4'h3;
	localparam logic [3:0]     OFF_PRIO_EXT1    = 4'h4;
	localparam logic [3:0]     OFF_PRIO_EXT2    = 4'h5;
	localparam logic [3:0]     OFF_EVT_STATUS   = 4'h6;
	localparam logic [3:0]     OFF_EVT_MASK     = 4'h7;
	localparam logic [3:0]     OFF_STATE        = 4'h8;
	localparam logic [16:0]    ENABLE_RESET     = 17'h00000;
	localparam logic [16:0]    PRIO_RESET       = 17'h00000;
	localparam logic [2:0]     EVT_RESET        = 3'h0;
	localparam int             EVT_VECTOR       = 0;
	localparam int             EVT_PREEMPT      = 1;
	localparam int             EVT_RETURN       = 2;

	typedef struct packed {
		logic               valid;
		logic               high;
		logic [ORDER_W-1:0] order;
	} grant_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wrData;
		logic       wrStb;
		logic       rdStb;
	} reg_req_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CALL = 3'b010,
		ST_HOLD = 3'b100
	} seq_state_e;
endpackage : irq_vector_pkg

// ============================================================
// two-level fixed-order arbiter
module irq_priority_arbiter import irq_vector_pkg::*; (
	input  wire logic [NUM_SOURCES-1:0] request,
	input  wire logic [NUM_SOURCES-1:0] highPrio,
	input  wire logic                   activeHigh,
	input  wire logic                   activeLow,
	output grant_s                      grant
);
	function automatic logic [ORDER_W:0] firstSet(input logic [NUM_SOURCES-1:0] vec);
		logic [ORDER_W:0] res;
		res = '0;
		for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
			if (vec[i]) begin
				res = {1'b1, i[ORDER_W-1:0]};
			end
		end
		return res;
	endfunction : firstSet

	wire logic [ORDER_W:0] hiPick = firstSet(request & highPrio);
	wire logic [ORDER_W:0] loPick = firstSet(request & ~highPrio);
	// a running high routine blocks all; a running low routine admits only high
	wire logic             hiOk   = hiPick[ORDER_W] && !activeHigh;
	wire logic             loOk   = loPick[ORDER_W] && !activeHigh && !activeLow;

	// lower fixed order wins within a level
	assign grant.valid = hiOk || loOk;
	assign grant.high  = hiOk;
	assign grant.order = hiOk ? hiPick[ORDER_W-1:0] : loPick[ORDER_W-1:0];
endmodule : irq_priority_arbiter

/* File: instr_sequencer_model.sv */
`timescale 1ns/10ps
// ============================================================
// instruction sequencer stand-in: boundaries and returns
module instr_sequencer_model (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic [3:0] instrLen,
	input  wire logic       retiReq,
	output logic            instrBoundary,
	output logic            retiDone
);
	logic [3:0] cnt_reg;
	logic       retiPend_reg;
	wire        wrap;

	// every instruction lasts instrLen clocks; 1 gives a boundary each cycle
	assign wrap = (cnt_reg + 4'h1 >= instrLen);

	// ============================================================
	// a return request is held until the next boundary, then fires once
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg       <= 4'h0;
			instrBoundary <= 1'b0;
			retiDone      <= 1'b0;
			retiPend_reg  <= 1'b0;
		end else begin
			cnt_reg       <= wrap ? 4'h0 : cnt_reg + 4'h1;
			instrBoundary <= wrap;
			retiDone      <= wrap & (retiPend_reg | retiReq);
			retiPend_reg  <= (retiPend_reg | retiReq) & ~wrap;
		end
	end
endmodule : instr_sequencer_model

/* File: tb_interrupt_vector_priority_latency.sv */
`timescale 1ns/10ps
// ============================================================
// self-checking bench
module tb_interrupt_vector_priority_latency import irq_vector_pkg::*; ;
	logic                                         core_clk;
	logic                                         rst_b;
	logic [NUM_SOURCES-1:0][FLAGS_PER_SOURCE-1:0] srcFlags;
	logic                                         busVoltageLevel;
	logic                                         cpuStall;
	logic                                         retiReq;
	logic [3:0]                                   instrLen;
	reg_req_s                                     regReq;
	logic                                         instrBoundary;
	logic                                         retiDone;
	logic [7:0]                                   rdData;
	logic                                         callActive;
	logic [15:0]                                  callVector;
	logic                                         vectorTaken;
	logic [NUM_SOURCES-1:0]                       hwClear;
	logic                                         irq;
	logic [7:0]                                   rv;
	logic [3:0]                                   p;
	int                                           n_mismatch;
	int                                           checks;
	int                                           seed;
	int                                           cyc;
	int                                           lat;

	irq_vector_priority_latency #(.FLAGS(FLAGS_PER_SOURCE)) uut (
		.core_clk(core_clk), .rst_b(rst_b), .srcFlags(srcFlags),
		.busVoltageLevel(busVoltageLevel), .instrBoundary(instrBoundary),
		.retiDone(retiDone), .cpuStall(cpuStall), .regReq(regReq), .rdData(rdData),
		.callActive(callActive), .callVector(callVector), .vectorTaken(vectorTaken),
		.hwClear(hwClear), .irq(irq));

	instr_sequencer_model partner (
		.core_clk(core_clk), .rst_b(rst_b), .instrLen(instrLen), .retiReq(retiReq),
		.instrBoundary(instrBoundary), .retiDone(retiDone));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// ============================================================
	// expectations and helpers
	function automatic logic [15:0] expVec(input int ord);
		return VECTOR_BASE + 16'(ord << VECTOR_STEP_LOG2);
	endfunction : expVec

	function automatic logic [16:0] expClr(input int ord);
		return (ord < 4) ? 17'h00001 << ord : 17'h00000;
	endfunction : expClr

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk) regReq <= {a, d, 1'b1, 1'b0};
		@(posedge core_clk) regReq.wrStb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk) regReq <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk) regReq.rdStb <= 1'b0;
		@(negedge core_clk) d = rdData;
	endtask : rd

	// latency counted from the cycle after the launching edge; negative skips it
	task automatic serve(input int ord, input int expLat);
		int n;
		int run;
		n = 0;
		run = 0;
		@(negedge core_clk);
		while (callActive !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		if (expLat >= 0) chk(n, expLat);
		chk(callVector, expVec(ord));
		chk(hwClear, expClr(ord));
		while (callActive === 1'b1 && run < 50) begin
			@(negedge core_clk);
			run++;
		end
		chk(run, CALL_CYCLES);
		chk(vectorTaken, 1'b1);
	endtask : serve

	task automatic quiet(input int n);
		int hit;
		hit = 0;
		repeat (n) begin
			@(negedge core_clk);
			if (callActive !== 1'b0) hit = 1;
		end
		chk(hit, 0);
	endtask : quiet

	// software clears the flags that hardware leaves set, then returns
	task automatic ret(input logic clr);
		@(posedge core_clk) begin
			if (clr) srcFlags <= '0;
			if (clr) busVoltageLevel <= 1'b0;
			retiReq <= 1'b1;
		end
		@(posedge core_clk) retiReq <= 1'b0;
		repeat (12) @(posedge core_clk);
	endtask : ret

	task automatic results;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results

	// a hang is cut short well beyond the expected run length
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			results();
		end
	end

	// ============================================================
	// main sequence
	initial begin
		seed = 22974;
		rst_b = 1'b0;
		srcFlags = '0;
		busVoltageLevel = 1'b0;
		cpuStall = 1'b0;
		retiReq = 1'b0;
		instrLen = 4'h1;
		regReq = '0;
		n_mismatch = 0;
		checks = 0;
		cyc = 0;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		@(negedge core_clk);
		chk(callVector, RESET_VECTOR);
		chk(irq, 1'b0);
		rd(OFF_STATE, rv);
		chk(rv, 8'h00);
		wr(OFF_ENABLE_MAIN, 8'hff);
		wr(OFF_ENABLE_EXT1, 8'hff);
		wr(OFF_ENABLE_EXT2, 8'h03);
		for (int o = 0; o < NUM_SOURCES; o++) begin
			p = 4'($random(seed));
			if (p == 4'h0) p = 4'h8;
			@(posedge core_clk);
			if (o == ORDER_BUS_LEVEL) busVoltageLevel <= 1'b1;
			else srcFlags[o] <= p;
			serve(o, DETECT_CYCLES + 1);
			ret(1'b1);
		end
		$display("vector table done");
		rd(OFF_EVT_STATUS, rv);
		chk(rv, 8'h05);
		chk(irq, 1'b0);
		wr(OFF_EVT_MASK, 8'h01);
		@(negedge core_clk) chk(irq, 1'b1);
		wr(OFF_EVT_STATUS, 8'h07);
		@(negedge core_clk) chk(irq, 1'b0);
		rd(4'hf, rv);
		chk(rv, 8'h00);
		$display("event registers done");
		wr(OFF_ENABLE_MAIN, 8'h7f);
		@(posedge core_clk) srcFlags[2] <= 4'h1;
		quiet(20);
		wr(OFF_ENABLE_MAIN, 8'hff);
		serve(2, 2);
		ret(1'b1);
		@(posedge core_clk) begin
			srcFlags[6] <= 4'h2;
			srcFlags[4] <= 4'h1;
		end
		serve(4, 2);
		ret(1'b1);
		$display("enable and order done");
		@(posedge core_clk) srcFlags[4] <= 4'h1;
		serve(4, 2);
		@(posedge core_clk) srcFlags[2] <= 4'h1;
		quiet(20);
		wr(OFF_PRIO_EXT1, 8'h04);
		@(posedge core_clk) srcFlags[9] <= 4'h1;
		serve(9, 2);
		wr(OFF_PRIO_EXT2, 8'h02);
		@(posedge core_clk) srcFlags[16] <= 4'h1;
		quiet(20);
		@(posedge core_clk) begin
			srcFlags[9] <= 4'h0;
			srcFlags[16] <= 4'h0;
		end
		ret(1'b0);
		quiet(10);
		ret(1'b1);
		rd(OFF_EVT_STATUS, rv);
		chk(rv[1], 1'b1);
		wr(OFF_PRIO_EXT1, 8'h00);
		wr(OFF_PRIO_EXT2, 8'h00);
		$display("preemption done");
		@(posedge core_clk) instrLen <= 4'h8;
		@(posedge core_clk) srcFlags[5] <= 4'h1;
		serve(5, -1);
		@(posedge core_clk) retiReq <= 1'b1;
		@(posedge core_clk) retiReq <= 1'b0;
		lat = 0;
		while (retiDone !== 1'b1 && lat < 30) begin
			@(negedge core_clk);
			lat++;
		end
		serve(5, 8);
		ret(1'b1);
		@(posedge core_clk) instrLen <= 4'h1;
		$display("return latency done");
		@(posedge core_clk) begin
			cpuStall <= 1'b1;
			srcFlags[1] <= 4'h4;
		end
		fork
			serve(1, 4);
			begin
				repeat (3) @(posedge core_clk);
				cpuStall <= 1'b0;
			end
		join
		ret(1'b1);
		$display("stall done");
		results();
	end
endmodule : tb_interrupt_vector_priority_latency
